// ==== asp_pkg.sv ====
// Shared constants, types and register map of the asynchronous serial port
package asp_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00; // serial_control_reg
    localparam logic [7:0] BUF_OFS    = 8'h04; // serial_buffer
    localparam logic [7:0] RELOAD_OFS = 8'h08; // internal baud generator reload
    localparam logic [7:0] CONV_OFS   = 8'h0c; // converter_control_reg0
    localparam logic [7:0] POWER_OFS  = 8'h10; // power_control_reg

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MODE_LSB   = 0;
    localparam int FILT_BIT   = 2;
    localparam int TX9_BIT    = 3;
    localparam int RX9_BIT    = 4;
    localparam int TXDONE_BIT = 5;
    localparam int RXDONE_BIT = 6;
    localparam int GSEL_BIT   = 7;
    localparam int DBL_BIT    = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [9:0] RELOAD_RST = 10'h3d9;
    localparam logic [8:0] RX_SR_RST  = 9'h1ff;

    // ------------------------------------------------------------------
    // Bit timing counts (sixteenths of a bit time; TX_LAST_10 and TX_LAST_11 count shifts)
    // ------------------------------------------------------------------
    localparam logic [3:0] DIV_LAST    = 4'hf;
    localparam logic [3:0] SAMPLE_A    = 4'h7;
    localparam logic [3:0] SAMPLE_B    = 4'h8;
    localparam logic [3:0] SAMPLE_C    = 4'h9;
    localparam logic [3:0] TX_LAST_10  = 4'h7;
    localparam logic [3:0] TX_LAST_11  = 4'h8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ASP_MODE_SHIFT = 2'b00, // not supported, runs as ten-bit mode
        ASP_MODE_10    = 2'b01,
        ASP_MODE_11F   = 2'b10,
        ASP_MODE_11V   = 2'b11
    } asp_mode_t;

    typedef enum logic [2:0] {
        RX_HUNT  = 3'b001,
        RX_FRAME = 3'b010,
        RX_TAIL  = 3'b100
    } asp_rx_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } asp_apb_req_t;

endpackage

// ==== asp_baud_gen.sv ====
// Free-running reload timer that paces the variable-rate modes
`timescale 1ns/1ps
`default_nettype none
module asp_baud_gen
    import asp_pkg::*;
#(
    parameter int W = 10
)
(
    // Clock and reset
    input  wire logic         clock_in,
    input  wire logic         srst_in,
    // Reload value and its write strobe
    input  wire logic [W-1:0] reload_in,
    input  wire logic         reload_wr_in,
    // One-cycle overflow pulse
    output var  logic         ovf_out
);
    logic [W-1:0] cnt_q;

    // Up-count, reload after all ones; a reload write restarts the count
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            cnt_q   <= W'(RELOAD_RST);
            ovf_out <= 1'b0;
        end else if (reload_wr_in) begin
            cnt_q   <= reload_in;
            ovf_out <= 1'b0;
        end else if (&cnt_q) begin
            cnt_q   <= reload_in;
            ovf_out <= 1'b1;
        end else begin
            cnt_q   <= cnt_q + W'(1);
            ovf_out <= 1'b0;
        end
    end
endmodule // asp_baud_gen
`default_nettype wire

// ==== asp_serial_port.sv ====
// Asynchronous serial port, ten-bit and eleven-bit frame modes, APB slave
//
// Contract
// - Ten-bit frame is low start, eight data bits LSB first, high stop.
// - Ten-bit mode stores the received stop bit in the received ninth flag.
// - Buffer write requests sending; ten-bit mode loads a one as ninth bit.
// - Sending starts only at the next divide-by-16 rollover.
// - Start bit first, data output one bit later, first shift after another.
// - Zeroes shift in; final shift, stop sending, done flag at 10th rollover.
// - Eleven-bit modes load the programmed ninth bit; first shift inserts one.
// - Eleven-bit modes finish and set done at the 11th rollover.
// - Receive line sampled at 16x; falling edge resets counter, loads ones.
// - Bit detector samples at counter states seven, eight and nine.
// - Accepted bit value is the majority of the three samples.
// - A first bit that is not zero aborts and resumes hunting.
// - Ones shift out left; start at leftmost position triggers final shift.
// - Ten-bit accept needs done clear and filter off or stop bit one.
// - Eleven-bit accept needs done clear and filter off or ninth bit one.
// - Rejected frames are dropped; hunting resumes, one bit later in 11-bit.
// - Eleven-bit frame adds a programmable ninth bit before the stop bit.
// - Eleven-bit mode ignores the received stop bit entirely.
// - Fixed-rate mode runs at clock/32, or clock/16 when doubled.
// - Variable-rate modes use timer 1 overflows or the internal generator.
// - Internal generator is a ten-bit up-counter reloading after all ones.
// - Generator-select bit 7 picks the internal generator over timer 1.
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port
    import asp_pkg::*;
#(
    parameter int RELOAD_W = 10
)
(
    // Clock and reset
    input  wire logic          clock_in,
    input  wire logic          srst_in,
    // APB slave
    input  wire asp_apb_req_t  apb_in,
    output var  logic [31:0]   prdata_out,
    output var  logic          pready_out,
    output var  logic          pslverr_out,
    // Timer 1 overflow pulse, same clock domain
    input  wire logic          timer1_ovf_in,
    // Serial lines
    input  wire logic          rxd_in,
    output var  logic          txd_out
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    asp_mode_t           mode_q;
    asp_rx_state_t       rx_st_q;
    logic                filt_q, tx9_q, rx9_q, tdone_q, rdone_q;
    logic                gsel_q, dbl_q, half_q, gen_ovf;
    logic [RELOAD_W-1:0] reload_q;
    logic [7:0]          rbuf_q;
    logic [31:0]         rd_mux;
    logic                acc, wr, buf_wr, ctrl_wr, reload_wr, is10;
    logic                src, tick;
    logic                tx_req_q, tx_busy_q, tx_data_q;
    logic [3:0]          tx_div_q, tx_idx_q;
    logic [8:0]          tx_sh_q;
    logic                tx_roll, tx_end;
    logic                rx_m_q, rx_s_q, rx_prev_q, rx_first_q, s7_q, s8_q;
    logic [3:0]          rx_div_q;
    logic [8:0]          rx_sr_q;
    logic                detect, decide, rbit, final_shift, accept;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic mapped(input logic [7:0] a);
        return a == CTRL_OFS || a == BUF_OFS || a == RELOAD_OFS ||
               a == CONV_OFS || a == POWER_OFS;
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign acc       = apb_in.psel & apb_in.penable & pready_out;
    assign wr        = acc & apb_in.pwrite;
    assign buf_wr    = wr & (apb_in.paddr == BUF_OFS);
    assign ctrl_wr   = wr & (apb_in.paddr == CTRL_OFS);
    assign reload_wr = wr & (apb_in.paddr == RELOAD_OFS);
    assign is10      = (mode_q == ASP_MODE_10) || (mode_q == ASP_MODE_SHIFT);

    // Read data mux; unmapped words read as zero
    always_comb begin
        rd_mux = '0;
        unique case (apb_in.paddr)
            CTRL_OFS: begin
                rd_mux[MODE_LSB +: 2] = mode_q;
                rd_mux[FILT_BIT]      = filt_q;
                rd_mux[TX9_BIT]       = tx9_q;
                rd_mux[RX9_BIT]       = rx9_q;
                rd_mux[TXDONE_BIT]    = tdone_q;
                rd_mux[RXDONE_BIT]    = rdone_q;
            end
            BUF_OFS:    rd_mux[7:0] = rbuf_q;
            RELOAD_OFS: rd_mux[RELOAD_W-1:0] = reload_q;
            CONV_OFS:   rd_mux[GSEL_BIT] = gsel_q;
            POWER_OFS:  rd_mux[DBL_BIT] = dbl_q;
            default:    rd_mux = '0;
        endcase
    end

    // Zero-wait answer: ready rises in the access phase of every transfer
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
        end else begin
            pready_out  <= apb_in.psel & ~apb_in.penable;
            pslverr_out <= apb_in.psel & ~apb_in.penable & ~mapped(apb_in.paddr);
            prdata_out  <= (apb_in.psel & ~apb_in.penable) ? rd_mux : '0;
        end
    end

    // ------------------------------------------------------------------
    // Control registers and flags; a hardware set beats a software clear
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            mode_q  <= ASP_MODE_SHIFT;
            filt_q  <= 1'b0;
            tx9_q   <= 1'b0;
            rx9_q   <= 1'b0;
            tdone_q <= 1'b0;
            rdone_q <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                mode_q  <= asp_mode_t'(apb_in.pwdata[MODE_LSB +: 2]);
                filt_q  <= apb_in.pwdata[FILT_BIT];
                tx9_q   <= apb_in.pwdata[TX9_BIT];
                rx9_q   <= apb_in.pwdata[RX9_BIT];
                tdone_q <= apb_in.pwdata[TXDONE_BIT];
                rdone_q <= apb_in.pwdata[RXDONE_BIT];
            end
            if (tx_end) begin
                tdone_q <= 1'b1;
            end
            if (accept) begin
                rx9_q   <= rbit;
                rdone_q <= 1'b1;
            end
        end
    end

    // Rate registers; the reload write also restarts the generator
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            reload_q <= RELOAD_W'(RELOAD_RST);
            gsel_q   <= 1'b0;
            dbl_q    <= 1'b0;
        end else if (wr) begin
            if (reload_wr) begin
                reload_q <= apb_in.pwdata[RELOAD_W-1:0];
            end
            if (apb_in.paddr == CONV_OFS) begin
                gsel_q <= apb_in.pwdata[GSEL_BIT];
            end
            if (apb_in.paddr == POWER_OFS) begin
                dbl_q <= apb_in.pwdata[DBL_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Sixteen-times bit clock
    // ------------------------------------------------------------------
    asp_baud_gen #(.W(RELOAD_W)) u_gen (
        .clock_in     (clock_in),
        .srst_in      (srst_in),
        .reload_in    (reload_wr ? apb_in.pwdata[RELOAD_W-1:0] : reload_q),
        .reload_wr_in (reload_wr),
        .ovf_out      (gen_ovf)
    );

    // Fixed mode counts every clock; otherwise pick the overflow source
    assign src  = (mode_q == ASP_MODE_11F) ? 1'b1 :
                  (gsel_q ? gen_ovf : timer1_ovf_in);
    assign tick = src & (dbl_q | half_q);

    // Divide-by-2 stage that the doubler bypasses
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            half_q <= 1'b0;
        end else if (src) begin
            half_q <= ~half_q;
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    assign tx_roll = tick & (tx_div_q == DIV_LAST);
    assign tx_end  = tx_roll & tx_busy_q & tx_data_q &
                     (tx_idx_q == (is10 ? TX_LAST_10 : TX_LAST_11));

    // Free-running bit-time divider so all bits align to its rollover
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            tx_div_q <= '0;
        end else if (tick) begin
            tx_div_q <= tx_div_q + 4'h1;
        end
    end

    // Send sequence: start, data phase, shifts; a late write wins its request
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            tx_req_q  <= 1'b0;
            tx_busy_q <= 1'b0;
            tx_data_q <= 1'b0;
            tx_idx_q  <= '0;
            tx_sh_q   <= '0;
            txd_out   <= 1'b1;
        end else begin
            if (tx_roll && !tx_busy_q && tx_req_q) begin
                tx_req_q  <= 1'b0;
                tx_busy_q <= 1'b1;
                tx_data_q <= 1'b0;
                tx_idx_q  <= '0;
                txd_out   <= 1'b0;
            end else if (tx_roll && tx_busy_q && !tx_data_q) begin
                tx_data_q <= 1'b1;
                txd_out   <= tx_sh_q[0];
            end else if (tx_roll && tx_busy_q) begin
                // Ten-bit inserts zeroes; eleven-bit puts the stop one first
                tx_sh_q   <= {~is10 & (tx_idx_q == 4'h0), tx_sh_q[8:1]};
                txd_out   <= tx_sh_q[1];
                tx_idx_q  <= tx_idx_q + 4'h1;
                if (tx_end) begin
                    tx_busy_q <= 1'b0;
                    tx_data_q <= 1'b0;
                end
            end
            if (buf_wr) begin
                tx_req_q <= 1'b1;
                tx_sh_q  <= {is10 | tx9_q, apb_in.pwdata[7:0]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    // Pin synchroniser; only the second stage feeds logic
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
        end else begin
            rx_m_q <= rxd_in;
            rx_s_q <= rx_m_q;
        end
    end

    assign detect      = tick & (rx_st_q == RX_HUNT) & rx_prev_q & ~rx_s_q;
    assign decide      = tick & (rx_st_q != RX_HUNT) & (rx_div_q == SAMPLE_C);
    assign rbit        = (s7_q & s8_q) | (s7_q & rx_s_q) | (s8_q & rx_s_q);
    assign final_shift = decide & (rx_st_q == RX_FRAME) & ~rx_first_q & ~rx_sr_q[8];
    assign accept      = final_shift & ~rdone_q & (~filt_q | rbit);

    // Sample history, divider and three-point samples
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rx_prev_q <= 1'b1;
            rx_div_q  <= '0;
            s7_q      <= 1'b1;
            s8_q      <= 1'b1;
        end else if (tick) begin
            rx_prev_q <= rx_s_q;
            rx_div_q  <= detect ? 4'h0 : rx_div_q + 4'h1;
            if (rx_div_q == SAMPLE_A) begin
                s7_q <= rx_s_q;
            end
            if (rx_div_q == SAMPLE_B) begin
                s8_q <= rx_s_q;
            end
        end
    end

    // Frame walk: hunt, frame, and the extra bit time of eleven-bit frames
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rx_st_q    <= RX_HUNT;
            rx_sr_q    <= RX_SR_RST;
            rx_first_q <= 1'b0;
            rbuf_q     <= '0;
        end else if (detect) begin
            rx_st_q    <= RX_FRAME;
            rx_sr_q    <= RX_SR_RST;
            rx_first_q <= 1'b1;
        end else if (decide) begin
            unique case (rx_st_q)
                RX_FRAME: begin
                    rx_first_q <= 1'b0;
                    if (rx_first_q && rbit) begin
                        rx_st_q <= RX_HUNT;
                    end else if (final_shift) begin
                        rx_sr_q <= {rx_sr_q[7:0], rbit};
                        rx_st_q <= is10 ? RX_HUNT : RX_TAIL;
                        if (accept) begin
                            rbuf_q <= rev8(rx_sr_q[7:0]);
                        end
                    end else begin
                        rx_sr_q <= {rx_sr_q[7:0], rbit};
                    end
                end
                RX_TAIL: rx_st_q <= RX_HUNT;
                default: rx_st_q <= RX_HUNT;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);

    sequence tx_begin_s;
        tx_roll && !tx_busy_q && tx_req_q;
    endsequence

    sequence tx_final_s;
        tx_end;
    endsequence

    tx_idle_high_a: assert property (!tx_busy_q |-> txd_out)
        else $error("transmit line low while idle");
    tx_start_bit_a: assert property (tx_begin_s |=> tx_busy_q && !txd_out)
        else $error("start bit not driven at rollover");
    tx_rollover_a: assert property ($rose(tx_busy_q) |-> $past(tx_roll))
        else $error("sending began off a rollover");
    tx_done_a: assert property (tx_final_s |=> tdone_q && !tx_busy_q && txd_out)
        else $error("send end did not set done");
    tx_len_a: assert property ($fell(tx_busy_q) |->
            $past(tx_idx_q) == (is10 ? TX_LAST_10 : TX_LAST_11))
        else $error("wrong number of bits sent");
    rx_edge_a: assert property (detect |=> rx_div_q == 4'h0 && rx_sr_q == RX_SR_RST)
        else $error("falling edge did not reset receiver");
    rx_false_a: assert property (decide && rx_first_q && rbit |=> rx_st_q == RX_HUNT)
        else $error("false start not rejected");
    rx_accept_a: assert property (accept |=>
            rdone_q && rx9_q == $past(rbit) && rbuf_q == rev8($past(rx_sr_q[7:0])))
        else $error("accepted frame not stored");
    rx_reject_a: assert property (final_shift && !accept |=> rbuf_q == $past(rbuf_q))
        else $error("rejected frame altered buffer");
    rx_tail_a: assert property (final_shift && !is10 |=> rx_st_q == RX_TAIL)
        else $error("extra bit time missing");
    rx_tail_hold_a: assert property (rx_st_q == RX_TAIL && !decide |=> rx_st_q == RX_TAIL)
        else $error("extra bit time cut short");
    fixed_rate_a: assert property (mode_q == ASP_MODE_11F && !dbl_q && tick |=> !tick)
        else $error("fixed rate faster than clock/32");

endmodule // asp_serial_port
`default_nettype wire

// ==== asp_remote_uart.sv ====
// Remote asynchronous transceiver model facing the serial port
`timescale 1ns/1ps
`default_nettype none
module asp_remote_uart (
    // Clock and bit length in clocks
    input  wire logic       clock_in,
    input  wire logic [7:0] bit_clks_in,
    // Serial lines
    input  wire logic       txd_in,
    output var  logic       rxd_out
);
    // ------------------------------------------------------------------
    // Sender
    // ------------------------------------------------------------------
    // Line rests at mark level so every start edge is visible
    initial rxd_out = 1'b1;

    // Frame bits LSB first; one clock of the chosen bit is flipped as noise
    task automatic send(input logic [10:0] bits, input int nb, input int glitch);
        for (int i = 0; i < nb; i++) begin
            for (int c = 0; c < int'(bit_clks_in); c++) begin
                @(posedge clock_in);
                rxd_out <= bits[i] ^ (i == glitch && c == int'(bit_clks_in) / 2);
            end
        end
        @(posedge clock_in);
        rxd_out <= 1'b1;
    endtask

    // Short low pulse, too brief to be a start bit
    task automatic blip(input int n);
        @(posedge clock_in);
        rxd_out <= 1'b0;
        repeat (n) @(posedge clock_in);
        rxd_out <= 1'b1;
    endtask

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    // Samples each bit at its centre, timed from the start edge
    task automatic catch(input int nb, output logic [10:0] bits);
        int n;
        bits = '1;
        n = 0;
        while (txd_in !== 1'b0 && n < 4000) begin
            @(posedge clock_in);
            n++;
        end
        repeat (bit_clks_in / 2) @(posedge clock_in);
        for (int i = 0; i < nb; i++) begin
            bits[i] = txd_in;
            repeat (bit_clks_in) @(posedge clock_in);
        end
    endtask
endmodule // asp_remote_uart
`default_nettype wire

// ==== async_serial_port_modes_1_2_3_tb.sv ====
// Self-checking testbench of the asynchronous serial port
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_modes_1_2_3_tb
    import asp_pkg::*;
;
    logic         clock_in;
    logic         srst_in;
    asp_apb_req_t req;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         t1;
    logic         rxd;
    logic         txd;
    logic [7:0]   bit_clks;
    logic [31:0]  rdat;
    logic         err;
    int           seed;
    int           checked;
    int           n_mismatch;

    // ------------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------------
    asp_serial_port uut (.clock_in(clock_in), .srst_in(srst_in), .apb_in(req),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .timer1_ovf_in(t1), .rxd_in(rxd), .txd_out(txd));
    asp_remote_uart rm (.clock_in(clock_in), .bit_clks_in(bit_clks), .txd_in(txd),
        .rxd_out(rxd));

    // Clock at 100 MHz
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    // Timer 1 overflow every second clock keeps the variable rate short
    always @(posedge clock_in) t1 <= ~t1;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock_in);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clock_in);
        req.penable <= 1'b1;
        do begin
            @(posedge clock_in);
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        req <= '0;
    endtask

    function automatic logic [10:0] frame(input logic [7:0] d, input logic n9);
        return {1'b1, n9, d, 1'b0};
    endfunction

    function automatic logic accept(input logic pre, input logic filt, input logic n9);
        return !pre && (!filt || n9);
    endfunction

    // Send one byte and compare the line against the expected frame
    task automatic tx_case(input logic [1:0] m, input logic n9);
        logic [7:0]  d;
        logic [10:0] got;
        d = 8'($random(seed));
        apb(1'b1, CTRL_OFS, 32'(m) | 32'(n9) << TX9_BIT);
        apb(1'b1, BUF_OFS, 32'(d));
        rm.catch(m[1] ? 11 : 10, got);
        check(32'(got), 32'(frame(d, ~m[1] | n9)), "tx frame");
        apb(1'b0, CTRL_OFS, 32'h0);
        check(32'(rdat[TXDONE_BIT]), 32'h1, "tx done");
        check(32'(txd), 32'h1, "tx idle");
    endtask

    // Receive one noisy frame under the given filter and flag state
    task automatic rx_case(input logic [1:0] m, input logic filt, input logic n9, input logic pre);
        logic [7:0]  d;
        logic [10:0] f;
        logic [31:0] old;
        logic        acc;
        d = 8'($random(seed));
        f = frame(d, n9);
        f[10] = 1'($random(seed));
        acc = accept(pre, filt, n9);
        apb(1'b1, CTRL_OFS, 32'(m) | 32'(filt) << FILT_BIT | 32'(pre) << RXDONE_BIT);
        apb(1'b0, BUF_OFS, 32'h0);
        old = rdat;
        rm.send(f, m[1] ? 11 : 10, 1 + int'($unsigned($random(seed)) % 8));
        repeat (4) @(posedge clock_in);
        apb(1'b0, CTRL_OFS, 32'h0);
        check(32'(rdat[RXDONE_BIT]), 32'(acc | pre), "rx done");
        check(32'(rdat[RX9_BIT]), 32'(acc & n9), "rx ninth");
        apb(1'b0, BUF_OFS, 32'h0);
        check(rdat, acc ? 32'(d) : old, "rx data");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        req = '0;
        srst_in = 1'b1;
        t1 = 1'b0;
        bit_clks = 8'h20;
        seed = 58205;
        checked = 0;
        n_mismatch = 0;
        repeat (20) @(posedge clock_in);
        srst_in <= 1'b0;
        @(posedge clock_in);
        check(32'(txd), 32'h1, "reset idle");
        apb(1'b0, CTRL_OFS, 32'h0);
        check(rdat, 32'h0, "ctrl reset");
        apb(1'b0, RELOAD_OFS, 32'h0);
        check(rdat, 32'(RELOAD_RST), "reload reset");
        apb(1'b1, 8'h20, 32'hff);
        check(32'(err), 32'h1, "unmapped error");
        apb(1'b0, 8'h20, 32'h0);
        check(rdat, 32'h0, "unmapped read");
        // Fixed rate, clock/32
        tx_case(2'b10, 1'b0);
        tx_case(2'b10, 1'b1);
        for (int i = 0; i < 6; i++) begin
            rx_case(2'b10, 1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
        end
        // Fixed rate doubled, clock/16
        apb(1'b1, POWER_OFS, 32'h80);
        bit_clks <= 8'h10;
        tx_case(2'b10, 1'b1);
        rx_case(2'b10, 1'b0, 1'b1, 1'b0);
        // Internal generator, ten-bit frames
        apb(1'b1, RELOAD_OFS, 32'h3fe);
        apb(1'b1, CONV_OFS, 32'h80);
        bit_clks <= 8'h20;
        tx_case(2'b01, 1'b0);
        tx_case(2'b00, 1'b0);
        rx_case(2'b01, 1'b0, 1'b0, 1'b0);
        rx_case(2'b01, 1'b1, 1'b0, 1'b0);
        rx_case(2'b01, 1'b0, 1'b1, 1'b1);
        // Timer 1 source, eleven-bit frames
        apb(1'b1, CONV_OFS, 32'h0);
        tx_case(2'b11, 1'b1);
        rx_case(2'b11, 1'b1, 1'b0, 1'b0);
        rx_case(2'b11, 1'b1, 1'b1, 1'b0);
        // Short low pulse is dropped, next frame still lands
        apb(1'b1, CTRL_OFS, 32'h3);
        rm.blip(6);
        repeat (64) @(posedge clock_in);
        apb(1'b0, CTRL_OFS, 32'h0);
        check(32'(rdat[RXDONE_BIT]), 32'h0, "false start");
        rx_case(2'b11, 1'b0, 1'b0, 1'b0);
        close_out;
    end

    // Watchdog, well past the expected run of about seven thousand clocks
    initial begin
        repeat (40000) @(posedge clock_in);
        n_mismatch++;
        close_out;
    end
endmodule // async_serial_port_modes_1_2_3_tb
`default_nettype wire
